/* File: psbel_pkg.sv */
// Constants, carrier types and state for the four-stage power event block.
// Assumes a 50 MHz clock and a 1 ms program cycle made by a divider.
`default_nettype none
package psbel_pkg;
   // Timing
   localparam int CLK_KHZ           = 50000;
   localparam int PROG_CYCLE_US     = 1000;
   localparam int CYCLE_CLKS        = CLK_KHZ * PROG_CYCLE_US / 1000;
   localparam int PRE_TRIG_MS       = 20;
   localparam int PRE_FAULT_MS      = 200;
   localparam int MAX_TRIP_S        = 1800;
   localparam logic [7:0] PRE_TRIG_TICKS  = 8'(PRE_TRIG_MS * 1000 / PROG_CYCLE_US);
   localparam logic [7:0] PRE_FAULT_TICKS = 8'(PRE_FAULT_MS * 1000 / PROG_CYCLE_US);
   localparam logic [20:0] DELAY_MAX = 21'(MAX_TRIP_S * 1000000 / PROG_CYCLE_US);
   // Sizes
   localparam int NSTAGE   = 4;
   localparam int NREC     = 12;
   localparam int HIST     = 256;
   localparam int DIV_W    = 20;
   // Release hysteresis, percent of setting
   localparam logic signed [24:0] PCT_FULL  = 25'sh0000064;
   localparam logic signed [24:0] PCT_OVER  = 25'sh0000061;
   localparam logic signed [24:0] PCT_UNDER = 25'sh0000067;
   // Register word addresses
   localparam logic [7:0] A_TIME    = 8'h00;
   localparam logic [7:0] A_EVMASK  = 8'h01;
   localparam logic [7:0] A_IRQ_ST  = 8'h02;
   localparam logic [7:0] A_IRQ_CLR = 8'h03;
   localparam logic [7:0] A_IRQ_EN  = 8'h04;
   localparam logic [7:0] A_CNT_CLR = 8'h05;
   localparam logic [7:0] A_STATUS  = 8'h06;
   localparam logic [7:0] A_RECINFO = 8'h07;
   localparam logic [7:0] A_STG     = 8'h10;
   localparam logic [7:0] A_STG_END = 8'h30;
   localparam logic [7:0] A_REC     = 8'h40;
   localparam logic [7:0] A_REC_END = 8'ha0;
   // Stage word offsets (stride 8)
   localparam logic [2:0] W_SET = 3'h0;
   localparam logic [2:0] W_MODE = 3'h1;
   localparam logic [2:0] W_DELAY = 3'h2;
   localparam logic [2:0] W_CNT_ST = 3'h3;
   localparam logic [2:0] W_CNT_TR = 3'h4;
   localparam logic [2:0] W_CNT_BL = 3'h5;
   // Reset values
   localparam logic [20:0] DELAY_RST  = 21'h00064;
   localparam logic [5:0]  EVMASK_RST = 6'h3f;
   // Event codes: even is ON, odd is OFF
   localparam logic [2:0] EV_START_ON = 3'h0;
   localparam logic [2:0] EV_TRIP_ON  = 3'h2;
   localparam logic [2:0] EV_BLOCK_ON = 3'h4;

   typedef enum logic [1:0] {ST_IDLE, ST_STARTED, ST_TRIPPED, ST_BLOCKED} psbel_stage_e_t;

   typedef struct packed {
      logic [1:0]  stage;
      logic [2:0]  code;
      logic [31:0] ts;
   } psbel_event_t;

   typedef struct packed {
      logic [31:0] ts;
      logic [1:0]  stage;
      logic [2:0]  code;
      logic [15:0] pre_trig;
      logic [15:0] fault;
      logic [15:0] pre_fault;
      logic [20:0] remain;
      logic [2:0]  group;
   } psbel_rec_t;

   typedef struct packed {
      logic [DIV_W-1:0]            div;
      logic [31:0]                 time_ms;
      psbel_stage_e_t [3:0]        st;
      logic [3:0][15:0]            setting;
      logic [3:0]                  under;
      logic [3:0][20:0]            delay;
      logic [3:0][20:0]            timer;
      logic [3:0]                  pick;
      logic [3:0]                  blk;
      logic [11:0][15:0]           cnt;
      logic [5:0]                  evmask;
      logic [11:0]                 irq_st;
      logic [11:0]                 irq_en;
      logic [23:0]                 pend;
      logic [31:0]                 cap_ts;
      logic [15:0]                 cap_pwr;
      logic [15:0]                 cap_pre_trig;
      logic [15:0]                 cap_pre_fault;
      logic [3:0][20:0]            cap_remain;
      logic [2:0]                  cap_group;
      logic [7:0]                  hptr;
      logic [HIST-1:0][15:0]       hist;
      psbel_rec_t [NREC-1:0]       rec;
      logic [3:0]                  rptr;
      logic [3:0]                  rcount;
      psbel_event_t                ev;
      logic                        ev_valid;
      logic [31:0]                 rdata;
   } psbel_state_t;
endpackage
`default_nettype wire

/* File: psbel_core.sv */
// Four-stage power protection stage logic with event log and records.
// Assumes pick-up setting and power share one signed scale and that
// block, power and group inputs are synchronous to clk_i.
// Behaviour
// R1: Blocking sampled once per program cycle
// R2: Pick-up unblocked starts stage and delay
// R3: Pick-up while blocked gives blocked only
// R4: Late blocking drops start, releases normally
// R5: Blocking must arrive 5 ms before trip
// R6: Definite-time delay from start to trip
// R7: Per-type mask selects ON/OFF event output
// R8: Every event carries transition time stamp
// R9: Clearable start, trip, blocked counters
// R10: Four independent separately configured stages
// R11: Six event kinds tagged by stage
// R12: Last twelve records kept, oldest overwritten
// R13: Record written on ON transitions only
// R14: Record holds time, event, powers, remain, group
// R15: Release hysteresis at 97 and 103 percent
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module psbel_core #(
   parameter int CYCLE_CLKS = psbel_pkg::CYCLE_CLKS
) (
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   // Process inputs
   input  wire logic signed [15:0]    power_i,
   input  wire logic [3:0]            block_i,
   input  wire logic [2:0]            group_i,
   // Register port
   input  wire logic [7:0]            addr_i,
   input  wire logic [31:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic [31:0]                rdata_o,
   // Stage indications
   output logic [3:0]                 start_o,
   output logic [3:0]                 trip_o,
   output logic [3:0]                 blocked_o,
   // Event stream and interrupt
   output logic                       event_valid_o,
   output psbel_pkg::psbel_event_t    event_o,
   output logic                       irq_o
);
   psbel_pkg::psbel_state_t s_q;
   psbel_pkg::psbel_state_t s_d;
   localparam int DIV_W = psbel_pkg::DIV_W;

   // Stage index counted from the stage base, not from raw address bits
   function automatic logic [1:0] stage_of(input logic [7:0] a);
      logic [7:0] off;
      off = a - psbel_pkg::A_STG;
      return off[4:3];
   endfunction

   function automatic logic pick_next(input logic pk, input logic under,
                                      input logic signed [15:0] set,
                                      input logic signed [15:0] p);
      logic signed [24:0] p100;
      logic signed [24:0] s97;
      logic signed [24:0] s103;
      logic               r;
      p100 = p * psbel_pkg::PCT_FULL;
      s97  = set * psbel_pkg::PCT_OVER;
      s103 = set * psbel_pkg::PCT_UNDER;
      if (!under) begin
         r = pk ? !(p100 < s97) : (p >= set);          // [R15]
      end else begin
         r = pk ? !(p100 > s103) : (p <= set);         // [R15]
      end
      return r;
   endfunction

   function automatic logic [4:0] first_set(input logic [23:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 23; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] indic(input psbel_pkg::psbel_stage_e_t st);
      // {blocked, trip, start}
      logic [2:0] r;
      r[0] = (st == psbel_pkg::ST_STARTED) || (st == psbel_pkg::ST_TRIPPED);
      r[1] = (st == psbel_pkg::ST_TRIPPED);
      r[2] = (st == psbel_pkg::ST_BLOCKED);
      return r;
   endfunction

   logic tick;
   assign tick = (s_q.div == DIV_W'(CYCLE_CLKS - 1));

   always_comb begin
      logic [2:0]  ind_o;
      logic [2:0]  ind_n;
      logic [4:0]  idx;
      logic [1:0]  stg;
      logic [2:0]  code;
      logic [7:0]  roff;
      logic [3:0]  ridx;
      logic [11:0] cclr;
      logic [23:0] newp;
      ind_o = 3'h0;
      ind_n = 3'h0;
      idx   = 5'h00;
      stg   = 2'h0;
      code  = 3'h0;
      roff  = 8'h00;
      ridx  = 4'h0;
      cclr  = 12'h000;
      newp  = 24'h000000;
      s_d   = s_q;
      s_d.ev_valid = 1'b0;
      s_d.rdata    = 32'h00000000;
      s_d.div      = tick ? '0 : s_q.div + DIV_W'(1);

      // Software writes first so hardware sets below win
      if (wr_i) begin
         unique case (addr_i)
            psbel_pkg::A_TIME:    s_d.time_ms = wdata_i;
            psbel_pkg::A_EVMASK:  s_d.evmask  = wdata_i[5:0];
            psbel_pkg::A_IRQ_CLR: s_d.irq_st  = s_q.irq_st & ~wdata_i[11:0];
            psbel_pkg::A_IRQ_EN:  s_d.irq_en  = wdata_i[11:0];
            psbel_pkg::A_CNT_CLR: cclr        = wdata_i[11:0];
            default: begin
               if (addr_i >= psbel_pkg::A_STG && addr_i < psbel_pkg::A_STG_END) begin
                  stg = stage_of(addr_i);
                  if (addr_i[2:0] == psbel_pkg::W_SET) begin
                     s_d.setting[stg] = wdata_i[15:0];          // [R10]
                  end
                  if (addr_i[2:0] == psbel_pkg::W_MODE) begin
                     s_d.under[stg] = wdata_i[0];
                  end
                  if (addr_i[2:0] == psbel_pkg::W_DELAY) begin
                     s_d.delay[stg] = (wdata_i[20:0] > psbel_pkg::DELAY_MAX) ?
                                      psbel_pkg::DELAY_MAX : wdata_i[20:0];
                  end
               end
            end
         endcase
      end
      for (int c = 0; c < 12; c++) begin
         if (cclr[c]) begin
            s_d.cnt[c] = 16'h0000;                               // [R9]
         end
      end

      // Drain one pending transition per clock
      if (|s_q.pend) begin
         idx  = first_set(s_q.pend);
         stg  = 2'(idx / 5'd6);
         code = 3'(idx % 5'd6);
         s_d.pend[idx]   = 1'b0;
         s_d.ev.stage    = stg;                                  // [R11]
         s_d.ev.code     = code;
         s_d.ev.ts       = s_q.cap_ts;                           // [R8]
         s_d.ev_valid    = s_q.evmask[code];                     // [R7]
         if (!code[0]) begin
            s_d.rec[s_q.rptr] = '{ts: s_q.cap_ts, stage: stg, code: code,
                                  pre_trig: s_q.cap_pre_trig, fault: s_q.cap_pwr,
                                  pre_fault: s_q.cap_pre_fault,
                                  remain: s_q.cap_remain[stg],
                                  group: s_q.cap_group};         // [R13] [R14]
            s_d.rptr   = (s_q.rptr == 4'(psbel_pkg::NREC - 1)) ? 4'h0 :
                         s_q.rptr + 4'h1;                        // [R12]
            s_d.rcount = (s_q.rcount == 4'(psbel_pkg::NREC)) ? s_q.rcount :
                         s_q.rcount + 4'h1;
         end
      end

      // Program cycle: sample inputs and step every stage
      if (tick) begin
         s_d.time_ms = s_d.time_ms + 32'h00000001;
         s_d.hist[s_q.hptr] = power_i;
         s_d.hptr    = s_q.hptr + 8'h01;
         s_d.cap_ts  = s_q.time_ms;                              // [R8]
         s_d.cap_pwr = power_i;
         s_d.cap_pre_trig  = s_q.hist[s_q.hptr - psbel_pkg::PRE_TRIG_TICKS];
         s_d.cap_pre_fault = s_q.hist[s_q.hptr - psbel_pkg::PRE_FAULT_TICKS];
         s_d.cap_group = group_i;
         for (int i = 0; i < psbel_pkg::NSTAGE; i++) begin     // [R10]
            s_d.blk[i]  = block_i[i];                            // [R1]
            s_d.pick[i] = pick_next(s_q.pick[i], s_q.under[i],
                                    s_q.setting[i], power_i);
            unique case (s_q.st[i])
               psbel_pkg::ST_IDLE: begin
                  if (s_d.pick[i] && block_i[i]) begin
                     s_d.st[i] = psbel_pkg::ST_BLOCKED;         // [R3]
                  end else if (s_d.pick[i]) begin
                     s_d.st[i]    = psbel_pkg::ST_STARTED;      // [R2]
                     s_d.timer[i] = 21'h000000;
                  end
               end
               psbel_pkg::ST_STARTED: begin
                  // Blocking is seen within one program cycle [R5]
                  if (block_i[i] || !s_d.pick[i]) begin
                     s_d.st[i] = psbel_pkg::ST_IDLE;            // [R4]
                  end else if (s_q.timer[i] + 21'h000001 >= s_q.delay[i]) begin
                     s_d.st[i] = psbel_pkg::ST_TRIPPED;         // [R6]
                     s_d.timer[i] = s_q.delay[i];
                  end else begin
                     s_d.timer[i] = s_q.timer[i] + 21'h000001;  // [R6]
                  end
               end
               psbel_pkg::ST_TRIPPED: begin
                  if (block_i[i] || !s_d.pick[i]) begin
                     s_d.st[i] = psbel_pkg::ST_IDLE;            // [R4]
                  end
               end
               psbel_pkg::ST_BLOCKED: begin
                  if (!s_d.pick[i]) begin
                     s_d.st[i] = psbel_pkg::ST_IDLE;
                  end
               end
            endcase
            s_d.cap_remain[i] = (s_d.st[i] == psbel_pkg::ST_STARTED) ?
                                s_q.delay[i] - s_d.timer[i] : 21'h000000; // [R14]
            ind_o = indic(s_q.st[i]);
            ind_n = indic(s_d.st[i]);
            for (int k = 0; k < 3; k++) begin
               if (ind_n[k] && !ind_o[k]) begin
                  newp[i*6 + k*2] = 1'b1;                        // [R11]
                  s_d.cnt[i*3 + k] = s_d.cnt[i*3 + k] + 16'h0001; // [R9]
                  s_d.irq_st[i*3 + k] = 1'b1;
               end
               if (!ind_n[k] && ind_o[k]) begin
                  newp[i*6 + k*2 + 1] = 1'b1;                    // [R11]
               end
            end
         end
         s_d.pend = s_d.pend | newp;
      end

      // Read data stands the cycle after the strobe only
      if (rd_i) begin
         unique case (addr_i)
            psbel_pkg::A_TIME:    s_d.rdata = s_q.time_ms;
            psbel_pkg::A_EVMASK:  s_d.rdata = {26'h0000000, s_q.evmask};
            psbel_pkg::A_IRQ_ST:  s_d.rdata = {20'h00000, s_q.irq_st};
            psbel_pkg::A_IRQ_EN:  s_d.rdata = {20'h00000, s_q.irq_en};
            psbel_pkg::A_STATUS:  s_d.rdata = {20'h00000, blocked_o, trip_o, start_o};
            psbel_pkg::A_RECINFO: s_d.rdata = {24'h000000, s_q.rcount, s_q.rptr};
            default: begin
               if (addr_i >= psbel_pkg::A_STG && addr_i < psbel_pkg::A_STG_END) begin
                  stg = stage_of(addr_i);
                  unique case (addr_i[2:0])
                     psbel_pkg::W_SET:    s_d.rdata = {16'h0000, s_q.setting[stg]};
                     psbel_pkg::W_MODE:   s_d.rdata = {31'h00000000, s_q.under[stg]};
                     psbel_pkg::W_DELAY:  s_d.rdata = {11'h000, s_q.delay[stg]};
                     psbel_pkg::W_CNT_ST: s_d.rdata = {16'h0000, s_q.cnt[stg*3]};
                     psbel_pkg::W_CNT_TR: s_d.rdata = {16'h0000, s_q.cnt[stg*3 + 1]};
                     psbel_pkg::W_CNT_BL: s_d.rdata = {16'h0000, s_q.cnt[stg*3 + 2]};
                     default:             s_d.rdata = 32'h00000000;
                  endcase
               end else if (addr_i >= psbel_pkg::A_REC && addr_i < psbel_pkg::A_REC_END) begin
                  roff = addr_i - psbel_pkg::A_REC;
                  ridx = roff[6:3];
                  unique case (roff[2:0])
                     3'h0: s_d.rdata = s_q.rec[ridx].ts;
                     3'h1: s_d.rdata = {24'h000000, 1'b0, s_q.rec[ridx].group,
                                        1'b0, s_q.rec[ridx].code[2:1],
                                        s_q.rec[ridx].stage[0]} |
                                       {30'h00000000, s_q.rec[ridx].stage} << 8;
                     3'h2: s_d.rdata = {16'h0000, s_q.rec[ridx].pre_trig};
                     3'h3: s_d.rdata = {16'h0000, s_q.rec[ridx].fault};
                     3'h4: s_d.rdata = {16'h0000, s_q.rec[ridx].pre_fault};
                     3'h5: s_d.rdata = {11'h000, s_q.rec[ridx].remain};
                     default: s_d.rdata = 32'h00000000;
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q        <= '0;
         s_q.delay  <= {4{psbel_pkg::DELAY_RST}};
         s_q.evmask <= psbel_pkg::EVMASK_RST;
      end else begin
         s_q <= s_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < psbel_pkg::NSTAGE; g++) begin : g_ind
         logic [2:0] ind;
         assign ind          = indic(s_q.st[g]);
         assign start_o[g]   = ind[0];
         assign trip_o[g]    = ind[1];
         assign blocked_o[g] = ind[2];
      end
   endgenerate

   assign rdata_o       = s_q.rdata;
   assign event_valid_o = s_q.ev_valid;
   assign event_o       = s_q.ev;
   assign irq_o         = |(s_q.irq_st & s_q.irq_en);
endmodule // psbel_core
`default_nettype wire

/* File: psbel_blk_model.sv */
// Model of the blocking matrix that feeds the four stage blocking inputs.
// Assumes the bench raises requests right after a rising edge of clk_i.
`timescale 1ns/100ps
`default_nettype none
module psbel_blk_model #(
   parameter int LAG = 3
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // User logic request and blocking output
   input  wire logic [3:0] req_i,
   output logic [3:0]      block_o
);
   logic [LAG-1:0][3:0] pipe_q;

   // Slow answer on purpose, still far under the 5 ms margin before trip
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         pipe_q <= '0;
      else
         pipe_q <= (LAG*4)'({pipe_q, req_i});
   end
   assign block_o = pipe_q[LAG-1];
endmodule  // psbel_blk_model
`default_nettype wire

/* File: psbel_chk.sv */
// Port checker for the four-stage power event block.
// Assumes the tick divider starts from zero at reset release.
`timescale 1ns/100ps
`default_nettype none
module psbel_chk #(
   parameter int CYCLE_CLKS = psbel_pkg::CYCLE_CLKS
) (
   input wire logic                    clk_i,
   input wire logic                    resetn_i,
   input wire logic signed [15:0]      power_i,
   input wire logic [3:0]              block_i,
   input wire logic [2:0]              group_i,
   input wire logic [7:0]              addr_i,
   input wire logic [31:0]             wdata_i,
   input wire logic                    wr_i,
   input wire logic                    rd_i,
   input wire logic [31:0]             rdata_o,
   input wire logic [3:0]              start_o,
   input wire logic [3:0]              trip_o,
   input wire logic [3:0]              blocked_o,
   input wire logic                    event_valid_o,
   input wire psbel_pkg::psbel_event_t event_o,
   input wire logic                    irq_o
);
   logic [19:0] cnt_q;
   logic        tick;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   assign tick = (cnt_q == 20'(CYCLE_CLKS - 1));
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         cnt_q <= '0;
      else
         cnt_q <= tick ? 20'h0 : cnt_q + 20'h1;
   end

   tick_hold_a:
      assert property (!tick |=> $stable({start_o, trip_o, blocked_o})) else $error("moved off tick");
   start_unblocked_a:
      assert property ((start_o & ~$past(start_o) & $past(block_i)) == 4'h0)
         else $error("start while blocked");
   blocked_cause_a:
      assert property ((blocked_o & ~$past(blocked_o) & ~$past(block_i)) == 4'h0)
         else $error("blocked without block");
   block_excl_a:
      assert property ((blocked_o & start_o) == 4'h0) else $error("blocked and started");
   late_block_a:
      assert property (tick && (start_o & block_i) != 4'h0 |=> (start_o & $past(block_i)) == 4'h0)
         else $error("start kept under block");
   trip_after_start_a:
      assert property ((trip_o & ~(start_o & $past(start_o))) == 4'h0) else $error("trip no start");
   event_code_a:
      assert property (event_valid_o |-> event_o.code <= 3'h5) else $error("bad event code");
   event_slot_a:
      assert property (event_valid_o |-> cnt_q inside {[1:26]}) else $error("event off slot");

   cover property ($rose(|trip_o));
   cover property (|blocked_o);
   cover property (event_valid_o && event_o.code == 3'h3);
endmodule  // psbel_chk
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the four-stage power event block.
// Assumes a short program cycle of 64 clocks set through CYCLE_CLKS.
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int C = 64;
   logic                    clk_i = 1'b0;
   logic                    resetn_i = 1'b0;
   logic signed [15:0]      power_i = 16'sh0;
   logic [3:0]              blk_req = 4'h0;
   logic [3:0]              block_i;
   logic [2:0]              group_i = 3'h0;
   logic [7:0]              addr_i = 8'h0;
   logic [31:0]             wdata_i = 32'h0;
   logic                    wr_i = 1'b0;
   logic                    rd_i = 1'b0;
   logic [31:0]             rdata_o;
   logic [3:0]              start_o, trip_o, blocked_o;
   logic                    event_valid_o, irq_o;
   psbel_pkg::psbel_event_t event_o;
   psbel_pkg::psbel_event_t evq[$];
   int                      miscompares = 0, checks = 0, cyc, n1, n3;
   int                      scyc[4], tcyc[4];
   logic [31:0]             rv, sts[4];
   logic [20:0]             dly[4];
   logic [15:0]             set_v;
   logic [2:0]              grp;

   always #10 clk_i = ~clk_i;

   psbel_core #(.CYCLE_CLKS(C)) u_dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .power_i(power_i), .block_i(block_i),
      .group_i(group_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
      .event_valid_o(event_valid_o), .event_o(event_o), .irq_o(irq_o));
   psbel_blk_model #(.LAG(3)) u_blk (
      .clk_i(clk_i), .resetn_i(resetn_i), .req_i(blk_req), .block_o(block_i));

   function automatic logic [7:0] sa(input int s, input int w);
      return psbel_pkg::A_STG + 8'(8 * s + w);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   task automatic tk(input int n);
      repeat (n * C) @(posedge clk_i);
      #1;
   endtask
   // Logs valid events and the first rise of start and trip per stage
   task automatic mon(input int n);
      evq.delete();
      cyc = 0;
      scyc = '{default: -1};
      tcyc = '{default: -1};
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         #1;
         cyc++;
         if (event_valid_o === 1'b1) evq.push_back(event_o);
         for (int s = 0; s < 4; s++) begin
            if (start_o[s] === 1'b1 && scyc[s] < 0) scyc[s] = cyc;
            if (trip_o[s] === 1'b1 && tcyc[s] < 0) tcyc[s] = cyc;
         end
      end
   endtask
   task automatic stop_test;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk_i);
      miscompares++;
      stop_test();
   end

   initial begin
      rv = $urandom(32'hf9c4);
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      rdchk(sa(1, 2), 32'h64);
      rdchk(8'h01, 32'h3f);
      rdchk(8'hf0, 32'h0);
      set_v = 16'(100 * (1 + $urandom_range(0, 9)));
      grp = 3'($urandom_range(0, 7));
      @(posedge clk_i);
      group_i <= grp;
      power_i <= 16'($urandom_range(0, 90));
      for (int s = 0; s < 4; s++) begin
         dly[s] = 21'(10 + 2 * s + $urandom_range(0, 3));
         wr(sa(s, 0), 32'(set_v));
         wr(sa(s, 2), 32'(dly[s]));
      end
      wr(8'h04, 32'hfff);
      $display("test config done");
      // Pick-up on all stages, each with its own delay
      @(posedge clk_i);
      power_i <= 16'sd2000;
      mon(22 * C);
      for (int s = 0; s < 4; s++) chk(32'(tcyc[s] - scyc[s]), 32'(dly[s]) * C);
      chk(32'(evq.size()), 32'h8);
      foreach (evq[i]) begin
         if (evq[i].code == 3'h0) sts[evq[i].stage] = evq[i].ts;
         else chk(evq[i].ts - sts[evq[i].stage], 32'(dly[evq[i].stage]));
      end
      rdchk(8'h02, 32'h6db);
      chk(32'(irq_o), 32'h1);
      wr(8'h04, 32'h0);
      chk(32'(irq_o), 32'h0);
      wr(8'h04, 32'hfff);
      wr(8'h03, 32'hfff);
      chk(32'(irq_o), 32'h0);
      for (int s = 0; s < 4; s++) rdchk(sa(s, 4), 32'h1);
      wr(8'h05, 32'h249);
      rdchk(sa(2, 3), 32'h0);
      rdchk(sa(2, 4), 32'h1);
      $display("test trip done");
      // Hold exactly at the hysteresis edge, release just below, start OFF masked
      wr(8'h01, 32'h3d);
      @(posedge clk_i);
      power_i <= 16'(set_v * 97 / 100);
      tk(3);
      chk(32'(start_o), 32'hf);
      @(posedge clk_i);
      power_i <= 16'(set_v * 97 / 100 - 1);
      mon(3 * C);
      chk(32'({start_o, trip_o}), 32'h0);
      n1 = 0;
      n3 = 0;
      foreach (evq[i]) begin
         n1 += int'(evq[i].code == 3'h1);
         n3 += int'(evq[i].code == 3'h3);
      end
      chk(32'(n1), 32'h0);
      chk(32'(n3), 32'h4);
      $display("test release done");
      // Blocked pick-up, then late blocking of running stages
      wr(8'h01, 32'h3f);
      @(posedge clk_i);
      blk_req <= 4'h5;
      tk(2);
      @(posedge clk_i);
      power_i <= 16'sd2000;
      tk(2);
      chk(32'({blocked_o, start_o}), 32'h5a);
      @(posedge clk_i);
      blk_req <= 4'hf;
      tk(3);
      chk(32'({start_o, trip_o}), 32'h0);
      $display("test block done");
      // More ON events than the record ring holds
      @(posedge clk_i);
      blk_req <= 4'h0;
      power_i <= 16'sd0;
      tk(2);
      @(posedge clk_i);
      power_i <= 16'sd2000;
      tk(2);
      rd(8'h07, rv);
      chk(32'(rv[7:4]), 32'hc);
      rd(8'h41 + 8'(8 * ((int'(rv[3:0]) + 11) % 12)), rv);
      chk(32'({rv[9:8], rv[6:4]}), 32'({2'h3, grp}));
      $display("test records done");
      // Under mode on stage 0 holds at 103 percent, releases just above
      wr(sa(0, 1), 32'h1);
      @(posedge clk_i);
      power_i <= 16'(set_v);
      tk(3);
      chk(32'(start_o[0]), 32'h1);
      @(posedge clk_i);
      power_i <= 16'(set_v * 103 / 100);
      tk(3);
      chk(32'(start_o[0]), 32'h1);
      @(posedge clk_i);
      power_i <= 16'(set_v * 103 / 100 + 1);
      tk(2);
      chk(32'(start_o[0]), 32'h0);
      $display("test under done");
      stop_test();
   end
endmodule  // tb

bind psbel_core psbel_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
   .clk_i(clk_i), .resetn_i(resetn_i), .power_i(power_i), .block_i(block_i),
   .group_i(group_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
   .event_valid_o(event_valid_o), .event_o(event_o), .irq_o(irq_o));
`default_nettype wire
